// ==== hdl/ccpwm_consts.svh ====
// register offsets, field positions, reset values and counts of the pwm unit
`ifndef CCPWM_CONSTS_SVH
`define CCPWM_CONSTS_SVH

`define CCPWM_ADDR_W 4
`define CCPWM_DATA_W 8
`define CCPWM_NUM_CH 2

// per channel: base 3*ch, then buffer, active duty, control
`define CCPWM_CH_STRIDE 4'h3
`define CCPWM_OFS_DUTY_BUF 4'h0
`define CCPWM_OFS_ACT_DUTY 4'h1
`define CCPWM_OFS_CONTROL 4'h2
`define CCPWM_ADDR_PERIOD 4'h6
`define CCPWM_ADDR_TIMER 4'h7
`define CCPWM_ADDR_TCTRL 4'h8
`define CCPWM_ADDR_STATUS 4'h9

// control register fields
`define CCPWM_CTL_DLOW_HI 5
`define CCPWM_CTL_DLOW_LO 4
`define CCPWM_CTL_MODE_HI 3
`define CCPWM_CTL_MODE_LO 0
`define CCPWM_CTL_IMPL_W 6
`define CCPWM_CTL_RESET 6'h00
`define CCPWM_MODE_PWM 2'h3

// timer control fields
`define CCPWM_TC_PRE_HI 1
`define CCPWM_TC_PRE_LO 0
`define CCPWM_TC_ON 2
`define CCPWM_TC_POST_HI 6
`define CCPWM_TC_POST_LO 3
`define CCPWM_TC_RESET 7'h00
`define CCPWM_PERIOD_RESET 8'hff
`define CCPWM_TIMER_RESET 8'h00

// four system clocks make one increment of the unscaled timer
`define CCPWM_PHASES 4
`define CCPWM_FINE_W 6
`define CCPWM_LAST_PRE1 6'h03
`define CCPWM_LAST_PRE4 6'h0f
`define CCPWM_LAST_PRE16 6'h3f

`endif

// ==== hdl/ccpwm_pkg.sv ====
// types shared by the pwm unit
package ccpwm_pkg;
  typedef enum logic [1:0] {
    CCPWM_PRE_1 = 2'b00,
    CCPWM_PRE_4 = 2'b01,
    CCPWM_PRE_16 = 2'b10,
    CCPWM_PRE_16B = 2'b11
  } ccpwm_pre_e;
  typedef logic [7:0] ccpwm_byte_t;
  typedef logic [9:0] ccpwm_duty_t;
endpackage

// ==== hdl/ccpwm_chan_if.sv ====
// carrier between the shared period timer and one pwm channel
`timescale 1ns/100ps
interface ccpwm_chan_if;
  import ccpwm_pkg::*;
  logic restart;
  ccpwm_byte_t timer_val;
  logic [1:0] sub_cnt;
  logic wr_buf;
  logic wr_act;
  logic wr_ctl;
  ccpwm_byte_t wdata;
  ccpwm_byte_t buf_q;
  ccpwm_byte_t act_q;
  logic [5:0] ctl_q;
  logic pin;
  modport timer (output restart, timer_val, sub_cnt, wr_buf, wr_act, wr_ctl, wdata,
                 input buf_q, act_q, ctl_q, pin);
  modport chan (input restart, timer_val, sub_cnt, wr_buf, wr_act, wr_ctl, wdata,
                output buf_q, act_q, ctl_q, pin);
endinterface

// ==== hdl/ccpwm_channel.sv ====
// one pwm channel: duty buffers, control register and output latch
`timescale 1ns/100ps
`include "ccpwm_consts.svh"
module ccpwm_channel (
  input wire logic clk_sys,
  input wire logic rst,
  ccpwm_chan_if.chan cif
);
  import ccpwm_pkg::*;

  ccpwm_byte_t buf_reg;
  ccpwm_byte_t act_reg;
  logic [1:0] act_low_reg;
  logic [5:0] ctl_reg;
  logic pin_reg;

  // decode of mode and compare
  wire logic pwm_mode;
  wire ccpwm_duty_t act_duty;
  wire ccpwm_duty_t buf_duty;
  wire ccpwm_duty_t timer_ext;
  wire logic duty_match;
  wire logic ctl_clear;
  assign pwm_mode = (ctl_reg[`CCPWM_CTL_MODE_HI:`CCPWM_CTL_MODE_HI-1] == `CCPWM_MODE_PWM);
  assign buf_duty = {buf_reg, ctl_reg[`CCPWM_CTL_DLOW_HI:`CCPWM_CTL_DLOW_LO]};
  assign act_duty = {act_reg, act_low_reg};
  assign timer_ext = {cif.timer_val, cif.sub_cnt};
  assign duty_match = (act_duty == timer_ext);
  assign ctl_clear = cif.wr_ctl && (cif.wdata == 8'h00);

  // control register, top two bits not stored so they read as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_reg <= `CCPWM_CTL_RESET;
    end else if (cif.wr_ctl) begin
      ctl_reg <= cif.wdata[5:0];
    end
  end

  // data registers keep their contents through reset, no reset term
  always_ff @(posedge clk_sys) begin
    if (cif.wr_buf) begin
      buf_reg <= cif.wdata;
    end
  end

  // active duty loads at period restart in pwm mode, and by software write only outside pwm mode
  always_ff @(posedge clk_sys) begin
    if (cif.restart && pwm_mode) begin
      act_reg <= buf_duty[9:2];
      act_low_reg <= buf_duty[1:0];
    end else if (cif.wr_act && !pwm_mode) begin
      act_reg <= cif.wdata;
    end
  end

  // output latch: set at restart unless duty zero, cleared on duty match
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_reg <= 1'b0;
    end else if (ctl_clear || !pwm_mode) begin
      pin_reg <= 1'b0;
    end else if (cif.restart) begin
      pin_reg <= (buf_duty != 10'h000);
    end else if (duty_match) begin
      pin_reg <= 1'b0;
    end
  end

  assign cif.buf_q = buf_reg;
  assign cif.act_q = act_reg;
  assign cif.ctl_q = ctl_reg;
  // pin drops in the match cycle itself, so high time is exactly the duty count
  assign cif.pin = pin_reg && !duty_match;
endmodule

// ==== hdl/ccpwm_top.sv ====
// shared period timer, register port and two pwm channels
//
// What this block does
// - timer equal to period register clears timer on next increment, new period
// - pin goes high at each period start unless duty is zero
// - buffered duty moves into active latch on the restarting increment
// - duty is ten bits: buffer byte plus control bits five and four
// - duty writes allowed anytime; old active duty used until period ends
// - active duty register is read only while in pwm mode
// - active byte plus hidden two-bit latch double-buffer the duty
// - pin clears when active duty equals timer extended by two sub bits
// - duty longer than period never matches, pin stays high
// - postscaler only divides period-match flag rate, not pwm timing
// - writing zero to control forces output latch low
// - control top bits read zero; control resets to zero
// - duty registers undefined at power-up, kept across other resets
// - both channels share one period timer and update instant
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "ccpwm_consts.svh"
module ccpwm_top #(
  parameter int NUM_CH = `CCPWM_NUM_CH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`CCPWM_ADDR_W-1:0] reg_addr,
  input wire ccpwm_pkg::ccpwm_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CCPWM_DATA_W-1:0] reg_rdata,
  output logic [NUM_CH-1:0] pwm_output_pin
);
  import ccpwm_pkg::*;

  ccpwm_byte_t period_reg;
  ccpwm_byte_t timer_reg;
  logic [6:0] tctrl_reg;
  logic [`CCPWM_FINE_W-1:0] fine_reg;
  logic [3:0] post_cnt_reg;
  logic match_flag_reg;
  ccpwm_byte_t rdata_reg;
  logic [NUM_CH-1:0] pin_reg;

  ccpwm_chan_if chan_if[NUM_CH]();

  // timer control decode
  wire ccpwm_pre_e pre_sel;
  wire logic timer_on;
  wire logic [3:0] post_sel;
  assign pre_sel = ccpwm_pre_e'(tctrl_reg[`CCPWM_TC_PRE_HI:`CCPWM_TC_PRE_LO]);
  assign timer_on = tctrl_reg[`CCPWM_TC_ON];
  assign post_sel = tctrl_reg[`CCPWM_TC_POST_HI:`CCPWM_TC_POST_LO];

  // the fine counter covers phase clock and prescaler in one register
  wire logic [`CCPWM_FINE_W-1:0] fine_last;
  wire logic tick;
  wire logic [1:0] sub_bits;
  wire logic period_hit;
  wire logic restart;
  assign fine_last = (pre_sel == CCPWM_PRE_1) ? `CCPWM_LAST_PRE1 :
                     (pre_sel == CCPWM_PRE_4) ? `CCPWM_LAST_PRE4 : `CCPWM_LAST_PRE16;
  assign tick = timer_on && (fine_reg == fine_last);
  // top two bits of the fine count extend the timer to ten bits
  assign sub_bits = (pre_sel == CCPWM_PRE_1) ? fine_reg[1:0] :
                    (pre_sel == CCPWM_PRE_4) ? fine_reg[3:2] : fine_reg[5:4];
  assign period_hit = (timer_reg == period_reg);
  assign restart = tick && period_hit;

  // register decode
  wire logic wr_period;
  wire logic wr_timer;
  wire logic wr_tctrl;
  wire logic wr_status;
  wire logic post_done;
  assign wr_period = reg_wr && (reg_addr == `CCPWM_ADDR_PERIOD);
  assign wr_timer = reg_wr && (reg_addr == `CCPWM_ADDR_TIMER);
  assign wr_tctrl = reg_wr && (reg_addr == `CCPWM_ADDR_TCTRL);
  assign wr_status = reg_wr && (reg_addr == `CCPWM_ADDR_STATUS);
  assign post_done = restart && (post_cnt_reg == post_sel);

  // fine counter: restarts on a prescale change so the phase stays coherent
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fine_reg <= '0;
    end else if (!timer_on || wr_tctrl || tick) begin
      fine_reg <= '0;
    end else begin
      fine_reg <= fine_reg + 1'b1;
    end
  end

  // period timer, shared by all channels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_reg <= `CCPWM_TIMER_RESET;
    end else if (wr_timer) begin
      timer_reg <= reg_wdata;
    end else if (restart) begin
      timer_reg <= `CCPWM_TIMER_RESET;
    end else if (tick) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // period and timer control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      period_reg <= `CCPWM_PERIOD_RESET;
      tctrl_reg <= `CCPWM_TC_RESET;
    end else begin
      if (wr_period) begin
        period_reg <= reg_wdata;
      end
      if (wr_tctrl) begin
        tctrl_reg <= reg_wdata[6:0];
      end
    end
  end

  // postscaler counts period matches only; it never touches pwm timing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      post_cnt_reg <= 4'h0;
    end else if (wr_tctrl || post_done) begin
      post_cnt_reg <= 4'h0;
    end else if (restart) begin
      post_cnt_reg <= post_cnt_reg + 4'h1;
    end
  end

  // sticky match flag, write one to clear; a new match wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_flag_reg <= 1'b0;
    end else if (post_done) begin
      match_flag_reg <= 1'b1;
    end else if (wr_status && reg_wdata[0]) begin
      match_flag_reg <= 1'b0;
    end
  end

  // channels: one write decode and one instance each
  ccpwm_byte_t ch_rd[NUM_CH];
  logic [NUM_CH-1:0] ch_hit;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      wire logic [`CCPWM_ADDR_W-1:0] base;
      wire logic [`CCPWM_ADDR_W-1:0] rel;
      assign base = `CCPWM_ADDR_W'(g * 3);
      assign rel = reg_addr - base;
      assign ch_hit[g] = (reg_addr >= base) && (rel <= `CCPWM_OFS_CONTROL);
      assign chan_if[g].restart = restart;
      assign chan_if[g].timer_val = timer_reg;
      assign chan_if[g].sub_cnt = sub_bits;
      assign chan_if[g].wdata = reg_wdata;
      assign chan_if[g].wr_buf = reg_wr && ch_hit[g] && (rel == `CCPWM_OFS_DUTY_BUF);
      assign chan_if[g].wr_act = reg_wr && ch_hit[g] && (rel == `CCPWM_OFS_ACT_DUTY);
      assign chan_if[g].wr_ctl = reg_wr && ch_hit[g] && (rel == `CCPWM_OFS_CONTROL);
      assign ch_rd[g] = (rel == `CCPWM_OFS_DUTY_BUF) ? chan_if[g].buf_q :
                        (rel == `CCPWM_OFS_ACT_DUTY) ? chan_if[g].act_q :
                        {2'b00, chan_if[g].ctl_q};
      ccpwm_channel i_ccpwm_channel (
        .clk_sys(clk_sys),
        .rst(rst),
        .cif(chan_if[g])
      );
      // pin registered once more so the top output is a local flop
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_reg[g] <= 1'b0;
        end else begin
          pin_reg[g] <= chan_if[g].pin;
        end
      end
    end
  endgenerate

  // read selection; unmapped addresses read zero
  ccpwm_byte_t rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_hit[i]) begin
        rd_mux = ch_rd[i];
      end
    end
    case (reg_addr)
      `CCPWM_ADDR_PERIOD: rd_mux = period_reg;
      `CCPWM_ADDR_TIMER: rd_mux = timer_reg;
      `CCPWM_ADDR_TCTRL: rd_mux = {1'b0, tctrl_reg};
      `CCPWM_ADDR_STATUS: rd_mux = {7'h00, match_flag_reg};
      default: ;
    endcase
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pwm_output_pin = pin_reg;
endmodule

// ==== test/ccpwm_load.sv ====
// load on one pwm pin: measures high time and period in clocks
`timescale 1ns/100ps
module ccpwm_load (
  input wire logic clk_sys,
  input wire logic pin,
  output int high_len,
  output int per_len
);
  logic last = 1'b0;
  int hc = 0;
  int pc = 0;
  // pin is taken as a driven output: port direction already cleared
  always @(posedge clk_sys) begin
    last <= pin;
    pc <= (pin && !last) ? 1 : pc + 1;
    hc <= (pin && !last) ? 1 : hc + 1;
    if (pin && !last) begin
      per_len <= pc;
    end
    if (!pin && last) begin
      high_len <= hc;
    end
  end
endmodule

// ==== test/ccpwm_top_assertions.sv ====
// concurrent checks on the register port and pwm pins
`timescale 1ns/100ps
`include "ccpwm_consts.svh"
module ccpwm_top_assertions #(
  parameter int NUM_CH = `CCPWM_NUM_CH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`CCPWM_ADDR_W-1:0] reg_addr,
  input wire ccpwm_pkg::ccpwm_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CCPWM_DATA_W-1:0] reg_rdata,
  input wire logic [NUM_CH-1:0] pwm_output_pin
);
  import ccpwm_pkg::*;
  logic [5:0] ctl0_reg, ctl1_reg;
  ccpwm_byte_t buf0_reg, per_reg;
  logic [1:0] pre_reg;
  logic pin_q, wr_q, wr_q2, dirty_reg, rise;
  int rise_cnt, high_cnt, pre_n;
  assign rise = pwm_output_pin[0] && !pin_q;
  assign pre_n = pre_reg == 2'h0 ? 1 : (pre_reg == 2'h1 ? 4 : 16);
  // shadows of what software wrote
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl0_reg <= 6'h00;
      ctl1_reg <= 6'h00;
      per_reg <= 8'hff;
      pre_reg <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        4'h2: ctl0_reg <= reg_wdata[5:0];
        4'h5: ctl1_reg <= reg_wdata[5:0];
        4'h6: per_reg <= reg_wdata;
        4'h8: pre_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end
  // duty buffer survives reset, so its shadow does too
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr == 4'h0) buf0_reg <= reg_wdata;
  end
  // pin 0 timing; a write since the last rise spoils the figure
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      wr_q <= 1'b0;
      wr_q2 <= 1'b0;
      dirty_reg <= 1'b1;
      rise_cnt <= 0;
      high_cnt <= 0;
    end else begin
      pin_q <= pwm_output_pin[0];
      wr_q <= reg_wr;
      // a write on the restart edge itself shows up two cycles before the rise
      wr_q2 <= wr_q;
      rise_cnt <= rise ? 1 : rise_cnt + 1;
      high_cnt <= rise ? 1 : high_cnt + int'(pwm_output_pin[0]);
      dirty_reg <= reg_wr || (dirty_reg && !(rise && !wr_q && !wr_q2));
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_ctl0_readback: assert property (
    reg_rd && reg_addr == 4'h2 |=> reg_rdata == {2'b00, $past(ctl0_reg)})
    else $error("control 0 readback");
  a_ctl1_readback: assert property (
    reg_rd && reg_addr == 4'h5 |=> reg_rdata == {2'b00, $past(ctl1_reg)})
    else $error("control 1 readback");
  a_period_readback: assert property (
    reg_rd && reg_addr == 4'h6 |=> reg_rdata == $past(per_reg))
    else $error("period readback");
  a_off0_low: assert property (
    ctl0_reg[3:2] != 2'h3 [*3] |-> !pwm_output_pin[0]) else $error("pin 0 not low");
  a_off1_low: assert property (
    ctl1_reg[3:2] != 2'h3 [*3] |-> !pwm_output_pin[1]) else $error("pin 1 not low");
  a_period_len: assert property (
    $rose(pwm_output_pin[0]) && !dirty_reg |-> rise_cnt == (int'(per_reg) + 1) * 4 * pre_n)
    else $error("pwm period length");
  a_high_len: assert property (
    $fell(pwm_output_pin[0]) && !dirty_reg |->
    high_cnt == int'({buf0_reg, ctl0_reg[5:4]}) * pre_n) else $error("pwm high time");
  c_rise: cover property ($rose(pwm_output_pin[0]) && !dirty_reg);
  c_both: cover property (&pwm_output_pin);
  c_ro_write: cover property (reg_wr && reg_addr == 4'h1 && ctl0_reg[3:2] == 2'h3);
endmodule
bind ccpwm_top ccpwm_top_assertions #(.NUM_CH(NUM_CH)) i_ccpwm_top_assertions (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pwm_output_pin(pwm_output_pin));

// ==== test/tb_ccpwm_top.sv ====
// testbench for the pwm unit
`timescale 1ns/100ps
module tb_ccpwm_top;
  import ccpwm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  ccpwm_byte_t reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] pwm_output_pin;
  int high_len[2];
  int per_len[2];
  int fails = 0;
  int checked = 0;
  // 125 MHz
  always #4 clk_sys = ~clk_sys;
  ccpwm_top i_ccpwm_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_output_pin(pwm_output_pin));
  ccpwm_load i_ccpwm_load0 (.clk_sys(clk_sys), .pin(pwm_output_pin[0]),
    .high_len(high_len[0]), .per_len(per_len[0]));
  ccpwm_load i_ccpwm_load1 (.clk_sys(clk_sys), .pin(pwm_output_pin[1]),
    .high_len(high_len[1]), .per_len(per_len[1]));
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobes, changed right after the edge
  task wr(logic [3:0] a, ccpwm_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rchk(string what, logic [3:0] a, ccpwm_byte_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(what, reg_rdata, exp);
  endtask
  task t_reset;
    rchk("ctl0", 4'h2, 8'h00);
    rchk("ctl1", 4'h5, 8'h00);
    rchk("period", 4'h6, 8'hff);
    wr(4'h2, 8'hff);
    rchk("ctl0 top", 4'h2, 8'h3f);
    wr(4'h2, 8'h00);
  endtask
  // period 3, ch0 duty 6, ch1 duty 3 with low mode bits set
  task t_pwm;
    wr(4'h6, 8'h03);
    wr(4'h0, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h2c);
    wr(4'h5, 8'h3f);
    wr(4'h8, 8'h04);
    repeat (60) @(posedge clk_sys);
    @(negedge clk_sys);
    check("high0", high_len[0], 6);
    check("per0", per_len[0], 16);
    check("high1", high_len[1], 3);
    check("per1", per_len[1], 16);
    rchk("act0", 4'h1, 8'h01);
    rchk("flag", 4'h9, 8'h01);
  endtask
  // write just after a restart so the old duty must still hold
  task t_buffer;
    @(posedge pwm_output_pin[0]);
    wr(4'h0, 8'h02);
    rchk("act0 old", 4'h1, 8'h01);
    repeat (40) @(posedge clk_sys);
    rchk("act0 new", 4'h1, 8'h02);
    check("high0 new", high_len[0], 10);
    wr(4'h1, 8'h55);
    rchk("act0 ro", 4'h1, 8'h02);
  endtask
  // prescale 4 must stretch pwm timing fourfold; full postscale must not change it
  task t_prescale;
    wr(4'h8, 8'h7d);
    wr(4'h9, 8'h01);
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    check("per0 pre4", per_len[0], 64);
    check("high0 pre4", high_len[0], 40);
    rchk("flag post", 4'h9, 8'h00);
  endtask
  task t_limits;
    wr(4'h8, 8'h04);
    wr(4'h0, 8'h10);
    wr(4'h5, 8'h0c);
    wr(4'h3, 8'h00);
    repeat (40) @(posedge clk_sys);
    repeat (20) begin
      @(negedge clk_sys);
      check("pins", pwm_output_pin, 2'b01);
    end
  endtask
  task t_clear_keep;
    wr(4'h2, 8'h00);
    repeat (3) @(posedge clk_sys);
    check("pin0 off", pwm_output_pin[0], 1'b0);
    wr(4'h0, 8'h5a);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rchk("buf kept", 4'h0, 8'h5a);
    rchk("ctl1 rst", 4'h5, 8'h00);
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_pwm;
    t_buffer;
    t_prescale;
    t_limits;
    t_clear_keep;
    finish_test;
  end
  // whole run is under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    finish_test;
  end
endmodule
